// [dsse_alu_if.sv]
// Carrier between the execution core and its saturating subtractor
`default_nettype none
interface dsse_alu_if;
    logic [31:0] minuend;
    logic [31:0] subtrahend;
    logic        sat_mode;
    logic [31:0] difference;
    logic        overflow;
    modport core (output minuend, output subtrahend, output sat_mode,
                  input difference, input overflow);
    modport alu  (input minuend, input subtrahend, input sat_mode,
                  output difference, output overflow);
endinterface
`default_nettype wire

// [dsse_cfg.svh]
// Constants for the store and subtract execution slice
`ifndef DSSE_CFG_SVH
`define DSSE_CFG_SVH

// Whole-word opcodes
`define DSSE_OP_SAT_OFF     16'h7f8a
`define DSSE_OP_SAT_ON      16'h7f8b
`define DSSE_OP_P_MINUS     16'h7f90

// Masked opcode groups
`define DSSE_MSK_UPPER      16'hf800
`define DSSE_VAL_UPPER      16'h5800
`define DSSE_MSK_LOWER      16'hff00
`define DSSE_VAL_LOWER      16'h5000
`define DSSE_MSK_AUX        16'hfe00
`define DSSE_VAL_AUX        16'h3000
`define DSSE_MSK_SAVE       16'hff00
`define DSSE_VAL_SAVE       16'h7c00
`define DSSE_MSK_SUB        16'hf000
`define DSSE_VAL_SUB        16'h1000

// Instruction fields
`define DSSE_IND_POS        7
`define DSSE_INC_POS        5
`define DSSE_DEC_POS        4
`define DSSE_KEEP_ARP_POS   3
`define DSSE_NEXT_ARP_POS   0
`define DSSE_AUX_SEL_POS    8

// Saved status word layout
`define DSSE_ST_OV_POS      15
`define DSSE_ST_OVM_POS     14
`define DSSE_ST_INTERRUPT_MASK_BIT_POS    13
`define DSSE_ST_ARP_POS     8
`define DSSE_ST_DP_POS      0
`define DSSE_ST_FILL        16'h1efe
`define DSSE_SAVE_PAGE      1'b1

// Saturation limits
`define DSSE_SAT_POS        32'h7fffffff
`define DSSE_SAT_NEG        32'h80000000

// Reset values
`define DSSE_RST_ACC        32'h00000000
`define DSSE_RST_AR         16'h0000
`define DSSE_RST_FLAG       1'b0

`endif

// [dsse_dmem_model.sv]
// Data memory model standing on the far side of the execution slice
`default_nettype none
module dsse_dmem_model (
    // Clock
    input  wire logic        clk,
    // Write port driven by the slice
    input  wire logic        we,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    // Read port used to fetch operands
    input  wire logic [7:0]  rd_addr,
    output logic      [15:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    // Distinct start pattern so a missed write cannot look like a hit
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(i * 3 + 16'h00a5);
        end
    end
    // Word write on the strobe
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
    assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// [dsse_exec.sv]
// Execution core: saturation mode, stores, subtracts and status save
`default_nettype none
`include "dsse_cfg.svh"
// Operation
// - Saturation-on instruction sets saturation mode to 1.
// - On overflow with saturation mode, load largest positive or negative value.
// - Any arithmetic overflow sets the overflow flag.
// - Saturation mode is also loaded by status restore and saturation-off.
// - Product-subtract computes sum minus product into the sum register.
// - Product value is treated as signed two's complement.
// - Product-subtract updates overflow and saturates when mode is set.
// - Aux store writes auxiliary register 0 or 1 to memory.
// - Storing the current register with post-modify stores the modified value.
// - Direct status save forces page 1, offset from instruction.
// - Forced page leaves the stored page pointer unchanged.
// - Indirect status save addresses through the current auxiliary register.
// - Saved word: overflow 15, mode 14, mask 13, pointer 8, page 0.
// - Upper store writes top half of shifted sum copy, sum unchanged.
// - Shifted subtract sign-extends memory word, shifts it left with zero fill, subtracts it.
module dsse_exec
    import dsse_pkg::*;
#(
    parameter int PC_WIDTH = 12
)(
    // Clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                SRST,
    // Instruction issue with its fetched memory operand
    input  wire logic                INSTR_VALID,
    input  wire logic [15:0]         INSTR,
    input  wire logic [15:0]         OPERAND,
    // State owned by neighbouring slices
    input  wire logic [31:0]         P_REG,
    input  wire logic                INTERRUPT_MASK_BIT_IN,
    // Loads from neighbouring slices, taken while no instruction issues
    input  wire logic                RESTORE_EN,
    input  wire logic [15:0]         RESTORE_WORD,
    input  wire logic                ACC_LOAD_EN,
    input  wire logic [31:0]         ACC_LOAD_DATA,
    input  wire logic                AR_LOAD_EN,
    input  wire logic                AR_LOAD_SEL,
    input  wire logic [15:0]         AR_LOAD_DATA,
    // Data memory write port
    output logic                     DMEM_WE,
    output logic [7:0]               DMEM_ADDR,
    output logic [15:0]              DMEM_WDATA,
    // Architectural state
    output logic [31:0]              ACC,
    output logic                     OV_FLAG,
    output logic                     SAT_MODE,
    output logic                     ARP,
    output logic                     DP,
    output logic [15:0]              AR0_VALUE,
    output logic [15:0]              AR1_VALUE,
    output logic [PC_WIDTH-1:0]      PC
);
    dsse_alu_if   alu_bus ();
    dsse_op_type  op;
    logic         is_sub;
    logic         uses_mem;
    logic         ind;
    logic [15:0]  ar [2];
    logic [15:0]  cur_ar;
    logic [15:0]  next_ar;
    logic         next_arp;
    logic         page;
    logic [7:0]   eff_addr;
    logic [15:0]  aux_data;
    logic [31:0]  shifted_acc;
    logic [31:0]  sub_value;
    logic [15:0]  save_word;
    logic         run;
    logic         idle;

    dsse_sub_alu u_alu (
        .bus (alu_bus)
    );

    // Opcode decode
    always_comb begin
        op = DSSE_NONE;
        is_sub = 1'b0;
        if (INSTR == `DSSE_OP_SAT_OFF) begin
            op = DSSE_SAT_OFF;
        end else if (INSTR == `DSSE_OP_SAT_ON) begin
            op = DSSE_SAT_ON;
        end else if (INSTR == `DSSE_OP_P_MINUS) begin
            op = DSSE_P_MINUS;
        end else if ((INSTR & `DSSE_MSK_UPPER) == `DSSE_VAL_UPPER) begin
            op = DSSE_UPPER;
        end else if ((INSTR & `DSSE_MSK_LOWER) == `DSSE_VAL_LOWER) begin
            op = DSSE_LOWER;
        end else if ((INSTR & `DSSE_MSK_AUX) == `DSSE_VAL_AUX) begin
            op = DSSE_AUX;
        end else if ((INSTR & `DSSE_MSK_SAVE) == `DSSE_VAL_SAVE) begin
            op = DSSE_SAVE;
        end else if ((INSTR & `DSSE_MSK_SUB) == `DSSE_VAL_SUB) begin
            is_sub = 1'b1;
        end
    end

    assign run  = INSTR_VALID && (op != DSSE_NONE || is_sub);
    assign idle = !INSTR_VALID;
    assign uses_mem = is_sub || op == DSSE_UPPER || op == DSSE_LOWER
                   || op == DSSE_AUX || op == DSSE_SAVE;

    // Address generation, direct through the page bit or indirect through a pointer
    assign ind      = INSTR[`DSSE_IND_POS];
    assign cur_ar   = ARP ? ar[1] : ar[0];
    assign next_ar  = cur_ar + {15'h0000, INSTR[`DSSE_INC_POS]}
                             - {15'h0000, INSTR[`DSSE_DEC_POS]};
    assign next_arp = (ind && !INSTR[`DSSE_KEEP_ARP_POS]) ? INSTR[`DSSE_NEXT_ARP_POS] : ARP;
    assign page     = (op == DSSE_SAVE) ? `DSSE_SAVE_PAGE : DP;
    assign eff_addr = ind ? cur_ar[7:0] : {page, INSTR[6:0]};

    // Store data sources
    assign aux_data = (ind && INSTR[`DSSE_AUX_SEL_POS] == ARP) ? next_ar
                    : ar[INSTR[`DSSE_AUX_SEL_POS]];
    assign shifted_acc = ACC << INSTR[10:8];
    assign sub_value   = {{16{OPERAND[15]}}, OPERAND} << INSTR[11:8];
    assign save_word   = `DSSE_ST_FILL
                       | ({15'h0000, OV_FLAG}  << `DSSE_ST_OV_POS)
                       | ({15'h0000, SAT_MODE} << `DSSE_ST_OVM_POS)
                       | ({15'h0000, INTERRUPT_MASK_BIT_IN}  << `DSSE_ST_INTERRUPT_MASK_BIT_POS)
                       | ({15'h0000, ARP}      << `DSSE_ST_ARP_POS)
                       | ({15'h0000, DP}       << `DSSE_ST_DP_POS);

    // Subtractor operands
    assign alu_bus.minuend    = ACC;
    assign alu_bus.subtrahend = (op == DSSE_P_MINUS) ? P_REG : sub_value;
    assign alu_bus.sat_mode   = SAT_MODE;

    // Program counter, one step per issued instruction
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PC <= '0;
        end else if (INSTR_VALID) begin
            PC <= PC + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Accumulator
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ACC <= `DSSE_RST_ACC;
        end else if (run && (is_sub || op == DSSE_P_MINUS)) begin
            ACC <= alu_bus.difference;
        end else if (idle && ACC_LOAD_EN) begin
            ACC <= ACC_LOAD_DATA;
        end
    end

    // Overflow flag, sticky until a restore
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            OV_FLAG <= `DSSE_RST_FLAG;
        end else if (run && (is_sub || op == DSSE_P_MINUS) && alu_bus.overflow) begin
            OV_FLAG <= 1'b1;
        end else if (idle && RESTORE_EN) begin
            OV_FLAG <= RESTORE_WORD[`DSSE_ST_OV_POS];
        end
    end

    // Saturation mode
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            SAT_MODE <= `DSSE_RST_FLAG;
        end else if (run && op == DSSE_SAT_ON) begin
            SAT_MODE <= 1'b1;
        end else if (run && op == DSSE_SAT_OFF) begin
            SAT_MODE <= 1'b0;
        end else if (idle && RESTORE_EN) begin
            SAT_MODE <= RESTORE_WORD[`DSSE_ST_OVM_POS];
        end
    end

    // Pointer and page bits; the forced save page never reaches DP
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ARP <= `DSSE_RST_FLAG;
            DP  <= `DSSE_RST_FLAG;
        end else if (run && uses_mem && ind) begin
            ARP <= next_arp;
        end else if (idle && RESTORE_EN) begin
            ARP <= RESTORE_WORD[`DSSE_ST_ARP_POS];
            DP  <= RESTORE_WORD[`DSSE_ST_DP_POS];
        end
    end

    // Auxiliary registers, post-modified by indirect accesses
    for (genvar i = 0; i < 2; i++) begin : g_ar
        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                ar[i] <= `DSSE_RST_AR;
            end else if (run && uses_mem && ind && ARP == 1'(i)) begin
                ar[i] <= next_ar;
            end else if (idle && AR_LOAD_EN && AR_LOAD_SEL == 1'(i)) begin
                ar[i] <= AR_LOAD_DATA;
            end
        end
    end
    assign AR0_VALUE = ar[0];
    assign AR1_VALUE = ar[1];

    // Data memory write port
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            DMEM_WE    <= 1'b0;
            DMEM_ADDR  <= 8'h00;
            DMEM_WDATA <= 16'h0000;
        end else begin
            DMEM_WE <= run && (op == DSSE_UPPER || op == DSSE_LOWER
                            || op == DSSE_AUX || op == DSSE_SAVE);
            if (run && uses_mem) begin
                DMEM_ADDR <= eff_addr;
            end
            case (run ? op : DSSE_NONE) // Idle cycles keep the last store word
                DSSE_UPPER: DMEM_WDATA <= shifted_acc[31:16];
                DSSE_LOWER: DMEM_WDATA <= ACC[15:0];
                DSSE_AUX:   DMEM_WDATA <= aux_data;
                DSSE_SAVE:  DMEM_WDATA <= save_word;
                default:    DMEM_WDATA <= DMEM_WDATA;
            endcase
        end
    end

    // Checks
    a_sat_on_sets: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_SAT_ON |=> SAT_MODE) else $error("sat on failed");
    a_sat_clamp_value: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && (is_sub || op == DSSE_P_MINUS) && alu_bus.overflow && SAT_MODE
        |=> (ACC == `DSSE_SAT_POS) || (ACC == `DSSE_SAT_NEG)) else $error("no clamp");
    a_ov_sets_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && (is_sub || op == DSSE_P_MINUS) && alu_bus.overflow |=> OV_FLAG [*2])
        else $error("overflow flag not set");
    a_restore_mode: assert property (@(posedge REF_CLK) disable iff (SRST)
        idle && RESTORE_EN |=> SAT_MODE == $past(RESTORE_WORD[14])) else $error("restore");
    a_pminus_diff: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_P_MINUS && !alu_bus.overflow
        |=> ACC == $past(ACC) - $past(P_REG)) else $error("product subtract wrong");
    a_pminus_wrap: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_P_MINUS && alu_bus.overflow && !SAT_MODE
        |=> ACC == $past(ACC) - $past(P_REG) && OV_FLAG) else $error("wrap wrong");
    a_aux_direct: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_AUX && !ind
        |=> DMEM_WE && DMEM_WDATA == ($past(INSTR[8]) ? $past(ar[1]) : $past(ar[0])))
        else $error("aux store wrong");
    a_aux_modified: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_AUX && ind && INSTR[5] && !INSTR[4] && INSTR[8] == ARP
        |=> DMEM_WDATA == $past(cur_ar) + 16'h0001 && DMEM_ADDR == $past(cur_ar[7:0]))
        else $error("post-increment store wrong");
    a_save_page: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_SAVE && !ind
        |=> DMEM_ADDR == {1'b1, $past(INSTR[6:0])} && DP == $past(DP))
        else $error("save page wrong");
    a_save_indirect: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_SAVE && ind |=> DMEM_ADDR == $past(cur_ar[7:0]))
        else $error("save indirect address wrong");
    a_save_layout: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_SAVE |=> DMEM_WE && DMEM_WDATA[15] == $past(OV_FLAG)
        && DMEM_WDATA[14] == $past(SAT_MODE) && DMEM_WDATA[8] == $past(ARP)
        && DMEM_WDATA[13] == $past(INTERRUPT_MASK_BIT_IN)
        && DMEM_WDATA[0] == $past(DP) && DMEM_WDATA[12:9] == 4'hf) else $error("layout");
    a_upper_keep: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_UPPER |=> ACC == $past(ACC) && DMEM_WE) else $error("upper");
    a_sub_shift: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && is_sub && !alu_bus.overflow |=> ACC == $past(ACC) - $past(sub_value))
        else $error("shifted subtract wrong");
    a_sat_off_clears: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_SAT_OFF |=> !SAT_MODE) else $error("sat off failed");
    a_lower_store: assert property (@(posedge REF_CLK) disable iff (SRST)
        run && op == DSSE_LOWER |=> DMEM_WE && DMEM_WDATA == $past(ACC[15:0]))
        else $error("lower store wrong");
    a_pc_step: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID |=> PC == $past(PC) + {{(PC_WIDTH-1){1'b0}}, 1'b1})
        else $error("pc step wrong");
endmodule
`default_nettype wire

// [dsse_exec_test.sv]
// Self-checking bench for the store and subtract execution slice
`default_nettype none
module dsse_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, srst = 1, valid = 0, interrupt_mask_bit = 0;
    logic        rst_en = 0, acc_en = 0, ar_en = 0, ar_sel = 0;
    logic [15:0] instr = 0, operand = 0, rst_word = 0, ar_data = 0;
    logic [31:0] p_reg = 0, acc_data = 0, acc;
    logic        we, ov, sat, arp, dp;
    logic [7:0]  addr, rd_addr = 0;
    logic [15:0] wdata, ar0, ar1, rd_data;
    logic [11:0] pc, exp_pc = 0;
    int          fail_count = 0, cmp_count = 0;

    // Clock at 100 MHz
    always #5 clk = ~clk;

    dsse_exec #(.PC_WIDTH(12)) u_dsse_exec (
        .REF_CLK(clk), .SRST(srst), .INSTR_VALID(valid), .INSTR(instr),
        .OPERAND(operand), .P_REG(p_reg), .INTERRUPT_MASK_BIT_IN(interrupt_mask_bit), .RESTORE_EN(rst_en),
        .RESTORE_WORD(rst_word), .ACC_LOAD_EN(acc_en), .ACC_LOAD_DATA(acc_data),
        .AR_LOAD_EN(ar_en), .AR_LOAD_SEL(ar_sel), .AR_LOAD_DATA(ar_data),
        .DMEM_WE(we), .DMEM_ADDR(addr), .DMEM_WDATA(wdata), .ACC(acc),
        .OV_FLAG(ov), .SAT_MODE(sat), .ARP(arp), .DP(dp), .AR0_VALUE(ar0),
        .AR1_VALUE(ar1), .PC(pc));
    dsse_dmem_model u_dsse_dmem_model (.clk(clk), .we(we), .addr(addr),
        .wdata(wdata), .rd_addr(rd_addr), .rd_data(rd_data));

    // Verdict and end of run
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One instruction issued for one cycle, results looked at a half cycle later
    task automatic issue(input logic [15:0] op, input logic [15:0] opnd);
        @(negedge clk);
        instr = op;
        operand = opnd;
        valid = 1;
        @(negedge clk);
        valid = 0;
        exp_pc++;
        chk(pc, exp_pc);
    endtask

    // Side load: 0 accumulator, 1 auxiliary register, 2 status restore
    task automatic load(input int kind, input logic [31:0] v, input logic sel);
        @(negedge clk);
        acc_en = (kind == 0);
        ar_en = (kind == 1);
        rst_en = (kind == 2);
        acc_data = v;
        ar_data = v[15:0];
        rst_word = v[15:0];
        ar_sel = sel;
        @(negedge clk);
        acc_en = 0;
        ar_en = 0;
        rst_en = 0;
    endtask

    // Expected difference with overflow and saturation
    function automatic logic [31:0] sub_exp(input logic [31:0] a, input logic [31:0] b,
                                            input logic s, inout logic o);
        logic [32:0] r;
        r = {a[31], a} - {b[31], b};
        if (r[32] != r[31]) o = 1;
        if (r[32] != r[31] && s) return r[32] ? 32'h80000000 : 32'h7fffffff;
        return r[31:0];
    endfunction

    task automatic pm(input logic [31:0] a, input logic [31:0] p, input logic s,
                      inout logic o);
        logic [31:0] e;
        p_reg = p;
        load(0, a, 0);
        e = sub_exp(a, p, s, o);
        issue(16'h7f90, 16'h0000);
        chk(acc, e);
        chk(ov, o);
    endtask

    // Store, strobe width, then the word as the memory holds it
    task automatic store_chk(input logic [15:0] op, input logic [7:0] a,
                             input logic [15:0] d);
        issue(op, 16'h0000);
        chk(we, 1);
        chk({addr, wdata}, {a, d});
        @(negedge clk);
        chk(we, 0);
        chk(wdata, d);
        rd_addr = a;
        #1 chk(rd_data, d);
    endtask

    task automatic t_reset();
        chk(acc, 0);
        chk({ov, sat, arp, dp, we}, 0);
        chk({ar1, ar0}, 0);
        chk({addr, wdata}, 0);
        chk(pc, 0);
    endtask

    task automatic t_product();
        logic o;
        o = 0;
        load(2, 0, 0);
        pm(32'h0000003c, 32'h00000024, 0, o);
        pm(32'h00000018, 32'hffffffff, 0, o);
        issue(16'h7f8b, 16'h0000);
        chk(sat, 1);
        pm(32'h80000000, 32'h00000001, 1, o);
        pm(32'h7fffffff, 32'hffffffff, 1, o);
        issue(16'h7f8a, 16'h0000);
        chk(sat, 0);
        pm(32'h80000000, 32'h00000001, 0, o);
        load(2, 32'h4000, 0);
        chk({ov, sat}, 2'b01);
    endtask

    task automatic t_stores();
        int sh [3] = '{0, 1, 4};
        load(0, 32'h04208001, 0);
        foreach (sh[i]) begin
            store_chk(16'h5846 | 16'(sh[i] << 8), 8'd70,
                      16'((32'h04208001 << sh[i]) >> 16));
            chk(acc, 32'h04208001);
        end
        load(0, 32'h7c638421, 0);
        store_chk(16'h5047, 8'd71, 16'h8421);
    endtask

    task automatic t_aux();
        load(1, 32'h0037, 0);
        load(1, 32'h1234, 1);
        store_chk(16'h301e, 8'd30, 16'h0037);
        store_chk(16'h311f, 8'd31, 16'h1234);
        load(1, 32'd10, 0);
        store_chk(16'h30a8, 8'd10, 16'd11);
        chk(ar0, 16'd11);
        load(1, 32'd10, 0);
        store_chk(16'h3098, 8'd10, 16'd9);
        chk(ar0, 16'd9);
    endtask

    task automatic t_save();
        load(2, 32'h8100, 0);
        interrupt_mask_bit = 1;
        store_chk(16'h7c05, 8'h85, 16'hbffe);
        chk(dp, 0);
        load(2, 32'h4001, 0);
        interrupt_mask_bit = 0;
        load(1, 32'h0042, 0);
        store_chk(16'h7c81, 8'h42, 16'h5eff);
        chk(dp, 1);
        chk(arp, 1);
    endtask

    task automatic t_subs();
        logic        o;
        logic [31:0] e;
        o = 0;
        load(2, 0, 0);
        load(0, 32'h00000024, 0);
        rd_addr = 8'd59;
        #1 e = sub_exp(32'h24, {16'h0000, rd_data}, 0, o);
        issue(16'h103b, rd_data);
        chk(acc, e);
        chk(addr, 8'd59);
        e = sub_exp(e, 32'hfff80010, 0, o);
        issue(16'h143b, 16'h8001);
        chk(acc, e);
        chk(ov, o);
    endtask

    // Guard against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (12) @(negedge clk);
        srst = 0;
        t_reset();
        t_product();
        t_stores();
        t_aux();
        t_save();
        t_subs();
        stop_test();
    end
endmodule
`default_nettype wire

// [dsse_pkg.sv]
// Types for the store and subtract execution slice
`default_nettype none
package dsse_pkg;
    typedef enum logic [2:0] {
        DSSE_NONE    = 3'h0,
        DSSE_SAT_OFF = 3'h1,
        DSSE_SAT_ON  = 3'h2,
        DSSE_P_MINUS = 3'h3,
        DSSE_UPPER   = 3'h4,
        DSSE_LOWER   = 3'h5,
        DSSE_AUX     = 3'h6,
        DSSE_SAVE    = 3'h7
    } dsse_op_type;
endpackage
`default_nettype wire

// [dsse_sub_alu.sv]
// Saturating 32-bit subtractor
`default_nettype none
`include "dsse_cfg.svh"
module dsse_sub_alu
    import dsse_pkg::*;
(
    // Operands and result
    dsse_alu_if.alu bus
);
    logic [32:0] wide;

    // Both operands are signed; a 33-bit result exposes the true sign
    always_comb begin
        wide = {bus.minuend[31], bus.minuend} - {bus.subtrahend[31], bus.subtrahend};
        bus.overflow = wide[32] ^ wide[31];
        if (bus.overflow && bus.sat_mode) begin
            bus.difference = wide[32] ? `DSSE_SAT_NEG : `DSSE_SAT_POS;
        end else begin
            bus.difference = wide[31:0];
        end
    end
endmodule
`default_nettype wire
